// File: rtl/upes_defs.svh
// register offsets, field positions, reset values and timing counts of the
// pipe empty / frame status block; assumes a 32-bit AXI4-Lite word map
`ifndef UPES_DEFS_SVH
`define UPES_DEFS_SVH

`define UPES_NUM_PIPES 10
`define UPES_AW 12
// register indices; byte address is four times the index
`define UPES_IDX_EMPTY_FLAG 12'h04A
`define UPES_IDX_FRAME 12'h04C
`define UPES_IDX_UFRAME 12'h04E
`define UPES_IDX_INT_MAIN 12'h020
`define UPES_IDX_EMPTY_EN 12'h038
`define UPES_IDX_CTRL 12'h040
`define UPES_IDX_RESP_SEL 12'h060
// field positions
`define UPES_FRM_OVR_BIT 15
`define UPES_FRM_CRC_BIT 14
`define UPES_INT_EMPTY_BIT 10
`define UPES_CTRL_HOST_BIT 0
// response select encodings
`define UPES_RSEL_NAK 2'h0
`define UPES_RSEL_BUF 2'h1
`define UPES_RSEL_STALL 2'h3
// reset values
`define UPES_RST_FLAGS 10'h000
`define UPES_RST_RESP_SEL 20'h00000
`define UPES_RST_FRAME 11'h000
// timing
`define UPES_CLK_MHZ 100
`define UPES_FRAME_US 1000
`define UPES_UFRAMES 8
`define UPES_UFRAME_CYC ((`UPES_FRAME_US * `UPES_CLK_MHZ) / `UPES_UFRAMES)
// axi responses
`define UPES_RESP_OKAY 2'h0
`define UPES_RESP_SLVERR 2'h2

`endif

// File: rtl/upes_pkg.sv
// types of the pipe empty / frame status block
// assumes upes_defs.svh is on the include path
package upes_pkg;
  // per-cycle transfer events from the link engine
  typedef struct packed {
    logic tx_end;          // transmission finished
    logic fifo_empty;      // pipe fifo empty at that moment
    logic dbl_buf;         // pipe uses double buffering
    logic other_buf_busy;  // cpu/dma started filling the other buffer
    logic sw_clear;        // buffer emptied by auto_clear_mode or fifo_clear_cmd
    logic status_zlp;      // zero-length status stage IN packet
    logic rdy_ev;          // fifo_ready_event from the buffer logic
    logic rx_ok;           // packet received without handshake error
    logic rx_oversize;     // received size exceeded max packet size
    logic rx_err;          // crc, bit stuffing or similar error
    logic setup_active;    // setup transaction in progress
    logic [3:0] pipe;
  } upes_link_ev_s;

  // isochronous checks at token time
  typedef struct packed {
    logic tx_token;   // host: OUT due, peripheral: token received (tx pipe)
    logic tx_full;    // tx fifo completely written
    logic rx_token;   // host: IN due, peripheral: OUT received (rx pipe)
    logic rx_free;    // rx fifo completely free
    logic crc_err;    // crc or bit stuffing error on iso pipe
    logic [3:0] pipe;
  } upes_iso_ev_s;

  // start-of-frame seen on the bus in peripheral role
  typedef struct packed {
    logic valid;
    logic [10:0] frame;
    logic [2:0] uframe;
  } upes_sof_rx_s;

  // answers to the link engine
  typedef struct packed {
    logic empty_req;   // fifo_drained_event request
    logic rdy_ev;      // fifo_ready_event, aligned with empty_req
    logic [3:0] pipe;
    logic discard;     // drop the oversize packet
    logic stall_hs;    // answer STALL handshake
    logic not_ready;   // not_ready_event request
    logic [3:0] not_ready_pipe;
    logic sof_issue;   // host: issue start-of-frame now
  } upes_link_out_s;

  typedef logic [1:0] upes_rsel_t;
endpackage

// File: rtl/upes_axil_slave.sv
// AXI4-Lite slave front end: one write and one read under way at a time
// assumes the owner decodes addresses and supplies read data combinationally
`include "upes_defs.svh"
module upes_axil_slave (
  input wire logic mclk_i,
  input wire logic nrst_i,
  input wire logic [`UPES_AW-1:0] awaddr_i,
  input wire logic awvalid_i,
  output logic awready_o,
  input wire logic [31:0] wdata_i,
  input wire logic [3:0] wstrb_i,
  input wire logic wvalid_i,
  output logic wready_o,
  output logic [1:0] bresp_o,
  output logic bvalid_o,
  input wire logic bready_i,
  input wire logic [`UPES_AW-1:0] araddr_i,
  input wire logic arvalid_i,
  output logic arready_o,
  output logic [31:0] rdata_o,
  output logic [1:0] rresp_o,
  output logic rvalid_o,
  input wire logic rready_i,
  output logic wr_en_o,
  output logic [`UPES_AW-1:0] wr_addr_o,
  output logic [31:0] wr_data_o,
  output logic [3:0] wr_strb_o,
  input wire logic wr_ok_i,
  output logic [`UPES_AW-1:0] rd_addr_o,
  input wire logic [31:0] rd_data_i,
  input wire logic rd_ok_i
);
  logic aw_full_reg, w_full_reg, aw_full_next, w_full_next;
  logic bvalid_next, rvalid_next;
  logic aw_take, w_take, ar_take;

  // handshakes and next state; address and data may arrive in either order
  always_comb
  begin
    aw_take = awvalid_i & awready_o;
    w_take = wvalid_i & wready_o;
    ar_take = arvalid_i & arready_o;
    wr_en_o = aw_full_reg & w_full_reg & ~bvalid_o;
    aw_full_next = (aw_full_reg | aw_take) & ~wr_en_o;
    w_full_next = (w_full_reg | w_take) & ~wr_en_o;
    bvalid_next = wr_en_o | (bvalid_o & ~bready_i);
    rvalid_next = ar_take | (rvalid_o & ~rready_i);
  end

  assign rd_addr_o = araddr_i;

  // write channel state
  always_ff @(posedge mclk_i)
  begin
    if (!nrst_i)
    begin
      aw_full_reg <= 1'b0;
      w_full_reg <= 1'b0;
      awready_o <= 1'b0;
      wready_o <= 1'b0;
      bvalid_o <= 1'b0;
      bresp_o <= `UPES_RESP_OKAY;
      wr_addr_o <= '0;
      wr_data_o <= '0;
      wr_strb_o <= '0;
    end
    else
    begin
      aw_full_reg <= aw_full_next;
      w_full_reg <= w_full_next;
      awready_o <= ~aw_full_next & ~bvalid_next;
      wready_o <= ~w_full_next & ~bvalid_next;
      bvalid_o <= bvalid_next;
      if (aw_take)
        wr_addr_o <= awaddr_i;
      if (w_take)
      begin
        wr_data_o <= wdata_i;
        wr_strb_o <= wstrb_i;
      end
      if (wr_en_o)
        bresp_o <= wr_ok_i ? `UPES_RESP_OKAY : `UPES_RESP_SLVERR;
    end
  end

  // read channel: data captured at the address handshake
  always_ff @(posedge mclk_i)
  begin
    if (!nrst_i)
    begin
      arready_o <= 1'b0;
      rvalid_o <= 1'b0;
      rdata_o <= '0;
      rresp_o <= `UPES_RESP_OKAY;
    end
    else
    begin
      rvalid_o <= rvalid_next;
      arready_o <= ~rvalid_next;
      if (ar_take)
      begin
        rdata_o <= rd_ok_i ? rd_data_i : 32'h00000000;
        rresp_o <= rd_ok_i ? `UPES_RESP_OKAY : `UPES_RESP_SLVERR;
      end
    end
  end
endmodule // upes_axil_slave

// File: rtl/upes_sof_timer.sv
// frame and microframe counting for both roles
// assumes sof_rx_i is a one-cycle report of a received start-of-frame
`include "upes_defs.svh"
module upes_sof_timer #(
  parameter int UFRAME_CYC = `UPES_UFRAME_CYC
) (
  input wire logic mclk_i,
  input wire logic nrst_i,
  input wire logic host_i,
  input wire logic hs_i,
  input wire upes_pkg::upes_sof_rx_s sof_rx_i,
  output logic [10:0] frame_o,
  output logic [2:0] uframe_o,
  output logic sof_o
);
  import upes_pkg::*;
  localparam logic [16:0] ULAST = 17'(UFRAME_CYC - 1);
  logic [16:0] cnt_reg;
  logic [2:0] ucnt_reg;
  logic utick;

  assign utick = host_i & (cnt_reg == ULAST);

  // host: microframe tick every 125 us, start-of-frame every eighth tick
  always_ff @(posedge mclk_i)
  begin
    if (!nrst_i || !host_i)
    begin
      cnt_reg <= 17'h00000;
      ucnt_reg <= 3'h0;
    end
    else
    begin
      cnt_reg <= utick ? 17'h00000 : cnt_reg + 17'h00001;
      if (utick)
        ucnt_reg <= ucnt_reg + 3'h1;
    end
  end

  // frame number taken at issued or received start-of-frame
  always_ff @(posedge mclk_i)
  begin
    if (!nrst_i)
    begin
      frame_o <= `UPES_RST_FRAME;
      uframe_o <= 3'h0;
      sof_o <= 1'b0;
    end
    else
    begin
      sof_o <= utick & (ucnt_reg == 3'h7);
      if (host_i)
      begin
        if (utick && ucnt_reg == 3'h7)
          frame_o <= frame_o + 11'h001;
        uframe_o <= hs_i ? ucnt_reg : 3'h0;
      end
      else if (sof_rx_i.valid)
      begin
        frame_o <= sof_rx_i.frame;
        uframe_o <= hs_i ? sof_rx_i.uframe : 3'h0;
      end
      else if (!hs_i)
        uframe_o <= 3'h0;
    end
  end
endmodule // upes_sof_timer

// File: rtl/upes_top.sv
// pipe empty flags, frame number and microframe status of a dual-role usb controller
// assumes the link engine reports transfer events as one-cycle pulses, all on mclk_i
//
// How it works
// [R1] empty on BUF pipe sets flag; enable drives interrupt
// [R2] tx fifo empty at end raises request
// [R3] single-buffer non-default pipe: request with ready event
// [R4] double buffer refilling blocks the request
// [R5] software buffer clear raises no request
// [R6] peripheral status-stage zero-length IN: no request
// [R7] oversize receive: request, flag, discard, stall
// [R8] oversize: host silent, peripheral sends STALL
// [R9] no oversize request on errors or setup
// [R10] write zero clears empty flag, one keeps
// [R11] frame register: errors bits 15,14, frame low
// [R12] iso overrun sets flag and not-ready request
// [R13] error flags cleared by writing zero only
// [R14] host: iso fifo not ready at token time
// [R15] peripheral: token on unfilled iso tx pipe
// [R16] peripheral: OUT on not-free iso rx pipe
// [R17] iso crc error sets flag, not-ready request
// [R18] frame updated every issued or received sof
// [R19] software reads frame twice to compare
// [R20] microframe bits 2-0 read only, rest zero
// [R21] microframe shown only at high speed
// [R22] hardware set beats same-cycle software clear
`include "upes_defs.svh"
module upes_top #(
  parameter int UFRAME_CYC = `UPES_UFRAME_CYC
) (
  input wire logic mclk_i,
  input wire logic nrst_i,
  input wire logic [`UPES_AW-1:0] s_axil_awaddr_i,
  input wire logic s_axil_awvalid_i,
  output logic s_axil_awready_o,
  input wire logic [31:0] s_axil_wdata_i,
  input wire logic [3:0] s_axil_wstrb_i,
  input wire logic s_axil_wvalid_i,
  output logic s_axil_wready_o,
  output logic [1:0] s_axil_bresp_o,
  output logic s_axil_bvalid_o,
  input wire logic s_axil_bready_i,
  input wire logic [`UPES_AW-1:0] s_axil_araddr_i,
  input wire logic s_axil_arvalid_i,
  output logic s_axil_arready_o,
  output logic [31:0] s_axil_rdata_o,
  output logic [1:0] s_axil_rresp_o,
  output logic s_axil_rvalid_o,
  input wire logic s_axil_rready_i,
  input wire upes_pkg::upes_link_ev_s link_ev_i,
  input wire upes_pkg::upes_iso_ev_s iso_ev_i,
  input wire upes_pkg::upes_sof_rx_s sof_rx_i,
  input wire logic port0_hs_i,
  input wire logic port1_hs_i,
  output upes_pkg::upes_link_out_s link_o,
  output logic [2*`UPES_NUM_PIPES-1:0] pipe_response_select_o,
  output logic int_n_o
);
  import upes_pkg::*;

  logic wr_en, wr_ok, rd_ok;
  logic [`UPES_AW-1:0] wr_addr, rd_addr;
  logic [31:0] wr_data, rd_data;
  logic [3:0] wr_strb;
  logic [`UPES_NUM_PIPES-1:0] pipe_empty_flag_reg, pipe_empty_flag_next;
  logic [`UPES_NUM_PIPES-1:0] pipe_empty_irq_enable_reg, empty_set, empty_clr;
  logic [2*`UPES_NUM_PIPES-1:0] resp_sel_reg, resp_sel_next;
  logic host_reg;
  logic ovr_reg, crc_reg;
  logic [10:0] frame_count_field;
  logic [2:0] microframe_field;
  logic sof_issue;
  logic [15:0] lane_lo;
  upes_rsel_t rsel_now;
  logic pipe_buf, tx_req, ov_req, emp_req, single_rdy, ovr_set, crc_set;

  // word hit on a register index (byte address = 4 x index)
  function automatic logic hit(input logic [`UPES_AW-1:0] a, input logic [11:0] idx);
    hit = (a[`UPES_AW-1:2] == idx[`UPES_AW-3:0]);
  endfunction

  // any mapped register
  function automatic logic mapped(input logic [`UPES_AW-1:0] a);
    mapped = hit(a, `UPES_IDX_EMPTY_FLAG) | hit(a, `UPES_IDX_FRAME) | hit(a, `UPES_IDX_UFRAME)
           | hit(a, `UPES_IDX_INT_MAIN) | hit(a, `UPES_IDX_EMPTY_EN) | hit(a, `UPES_IDX_CTRL)
           | hit(a, `UPES_IDX_RESP_SEL);
  endfunction

  // bus front end
  upes_axil_slave u_bus (
    .mclk_i(mclk_i),
    .nrst_i(nrst_i),
    .awaddr_i(s_axil_awaddr_i),
    .awvalid_i(s_axil_awvalid_i),
    .awready_o(s_axil_awready_o),
    .wdata_i(s_axil_wdata_i),
    .wstrb_i(s_axil_wstrb_i),
    .wvalid_i(s_axil_wvalid_i),
    .wready_o(s_axil_wready_o),
    .bresp_o(s_axil_bresp_o),
    .bvalid_o(s_axil_bvalid_o),
    .bready_i(s_axil_bready_i),
    .araddr_i(s_axil_araddr_i),
    .arvalid_i(s_axil_arvalid_i),
    .arready_o(s_axil_arready_o),
    .rdata_o(s_axil_rdata_o),
    .rresp_o(s_axil_rresp_o),
    .rvalid_o(s_axil_rvalid_o),
    .rready_i(s_axil_rready_i),
    .wr_en_o(wr_en),
    .wr_addr_o(wr_addr),
    .wr_data_o(wr_data),
    .wr_strb_o(wr_strb),
    .wr_ok_i(wr_ok),
    .rd_addr_o(rd_addr),
    .rd_data_i(rd_data),
    .rd_ok_i(rd_ok)
  );

  // frame and microframe counters
  upes_sof_timer #(
    .UFRAME_CYC(UFRAME_CYC)
  ) u_sof (
    .mclk_i(mclk_i),
    .nrst_i(nrst_i),
    .host_i(host_reg),
    .hs_i(port0_hs_i | port1_hs_i), // [R21]
    .sof_rx_i(sof_rx_i),
    .frame_o(frame_count_field), // [R18]
    .uframe_o(microframe_field),
    .sof_o(sof_issue)
  );

  assign wr_ok = mapped(wr_addr);
  assign rd_ok = mapped(rd_addr);
  assign lane_lo = {{8{wr_strb[1]}}, {8{wr_strb[0]}}};

  // empty request qualification for the pipe named by the event
  always_comb
  begin
    rsel_now = resp_sel_reg[{link_ev_i.pipe, 1'b0} +: 2];
    pipe_buf = (rsel_now == `UPES_RSEL_BUF);
    tx_req = link_ev_i.tx_end & link_ev_i.fifo_empty                  // [R2]
           & ~link_ev_i.sw_clear                                      // [R5]
           & ~(link_ev_i.dbl_buf & link_ev_i.other_buf_busy)          // [R4]
           & ~(~host_reg & link_ev_i.status_zlp);                     // [R6]
    ov_req = link_ev_i.rx_ok & link_ev_i.rx_oversize
           & ~link_ev_i.rx_err & ~link_ev_i.setup_active;              // [R9]
    emp_req = tx_req | ov_req;                                         // [R7]
    single_rdy = tx_req & ~link_ev_i.dbl_buf & (link_ev_i.pipe != 4'h0); // [R3]
    empty_set = ((tx_req & pipe_buf) | ov_req) ?                       // [R1]
                (`UPES_NUM_PIPES'(1) << link_ev_i.pipe) : `UPES_RST_FLAGS;
    empty_clr = (wr_en && hit(wr_addr, `UPES_IDX_EMPTY_FLAG)) ?
                (~wr_data[`UPES_NUM_PIPES-1:0] & lane_lo[`UPES_NUM_PIPES-1:0]) : `UPES_RST_FLAGS; // [R10]
    pipe_empty_flag_next = (pipe_empty_flag_reg & ~empty_clr) | empty_set; // [R22]
  end

  // response select: software writes, oversize forces stall afterwards
  always_comb
  begin
    resp_sel_next = resp_sel_reg;
    if (wr_en && hit(wr_addr, `UPES_IDX_RESP_SEL))
    begin
      for (int i = 0; i < 2 * `UPES_NUM_PIPES; i++)
      begin
        if (wr_strb[i / 8])
          resp_sel_next[i] = wr_data[i];
      end
    end
    if (ov_req)
      resp_sel_next[{link_ev_i.pipe, 1'b0} +: 2] = `UPES_RSEL_STALL; // [R7]
  end

  // empty flags, enables, response select and role
  always_ff @(posedge mclk_i)
  begin
    if (!nrst_i)
    begin
      pipe_empty_flag_reg <= `UPES_RST_FLAGS;
      pipe_empty_irq_enable_reg <= `UPES_RST_FLAGS;
      resp_sel_reg <= `UPES_RST_RESP_SEL;
      host_reg <= 1'b0;
    end
    else
    begin
      pipe_empty_flag_reg <= pipe_empty_flag_next;
      resp_sel_reg <= resp_sel_next;
      if (wr_en && hit(wr_addr, `UPES_IDX_EMPTY_EN))
        pipe_empty_irq_enable_reg <= (pipe_empty_irq_enable_reg & ~lane_lo[`UPES_NUM_PIPES-1:0])
                                   | (wr_data[`UPES_NUM_PIPES-1:0] & lane_lo[`UPES_NUM_PIPES-1:0]);
      if (wr_en && hit(wr_addr, `UPES_IDX_CTRL) && wr_strb[0])
        host_reg <= wr_data[`UPES_CTRL_HOST_BIT];
    end
  end

  // iso error detection; the token checks read the same in both roles
  always_comb
  begin
    ovr_set = (iso_ev_i.tx_token & ~iso_ev_i.tx_full)   // [R14] [R15]
            | (iso_ev_i.rx_token & ~iso_ev_i.rx_free);   // [R14] [R16]
    crc_set = iso_ev_i.crc_err;                          // [R17]
  end

  // iso error flags: cleared by a zero in the high byte, set wins
  always_ff @(posedge mclk_i)
  begin
    if (!nrst_i)
    begin
      ovr_reg <= 1'b0;
      crc_reg <= 1'b0;
    end
    else
    begin
      if (ovr_set)
        ovr_reg <= 1'b1; // [R12] [R22]
      else if (wr_en && hit(wr_addr, `UPES_IDX_FRAME) && wr_strb[1] && !wr_data[`UPES_FRM_OVR_BIT])
        ovr_reg <= 1'b0; // [R13]
      if (crc_set)
        crc_reg <= 1'b1; // [R17] [R22]
      else if (wr_en && hit(wr_addr, `UPES_IDX_FRAME) && wr_strb[1] && !wr_data[`UPES_FRM_CRC_BIT])
        crc_reg <= 1'b0; // [R13]
    end
  end

  // read mux; unassigned bits read zero
  always_comb
  begin
    rd_data = 32'h00000000;
    if (hit(rd_addr, `UPES_IDX_EMPTY_FLAG))
      rd_data[`UPES_NUM_PIPES-1:0] = pipe_empty_flag_reg;
    else if (hit(rd_addr, `UPES_IDX_FRAME))
      rd_data[15:0] = {ovr_reg, crc_reg, 3'h0, frame_count_field}; // [R11]
    else if (hit(rd_addr, `UPES_IDX_UFRAME))
      rd_data[2:0] = microframe_field; // [R20]
    else if (hit(rd_addr, `UPES_IDX_INT_MAIN))
      rd_data[`UPES_INT_EMPTY_BIT] = |(pipe_empty_flag_reg & pipe_empty_irq_enable_reg); // [R1]
    else if (hit(rd_addr, `UPES_IDX_EMPTY_EN))
      rd_data[`UPES_NUM_PIPES-1:0] = pipe_empty_irq_enable_reg;
    else if (hit(rd_addr, `UPES_IDX_CTRL))
      rd_data[`UPES_CTRL_HOST_BIT] = host_reg;
    else if (hit(rd_addr, `UPES_IDX_RESP_SEL))
      rd_data[2*`UPES_NUM_PIPES-1:0] = resp_sel_reg;
  end

  // registered answers to the link engine and the interrupt pin
  always_ff @(posedge mclk_i)
  begin
    if (!nrst_i)
    begin
      link_o <= '0;
      int_n_o <= 1'b1;
      pipe_response_select_o <= `UPES_RST_RESP_SEL;
    end
    else
    begin
      link_o.empty_req <= emp_req;
      link_o.rdy_ev <= link_ev_i.rdy_ev | single_rdy; // [R3]
      link_o.pipe <= link_ev_i.pipe;
      link_o.discard <= ov_req;                       // [R7]
      link_o.stall_hs <= ov_req & ~host_reg;          // [R8]
      link_o.not_ready <= ovr_set | crc_set;          // [R12] [R17]
      link_o.not_ready_pipe <= iso_ev_i.pipe;
      link_o.sof_issue <= sof_issue;
      int_n_o <= ~|(pipe_empty_flag_next & pipe_empty_irq_enable_reg); // [R1]
      pipe_response_select_o <= resp_sel_next;
    end
  end

  a_oversize_flag: assert property (@(posedge mclk_i) disable iff (!nrst_i) // [R7]
    ov_req |=> pipe_empty_flag_reg[$past(link_ev_i.pipe)] && link_o.discard && link_o.empty_req)
    else $error("oversize packet did not set flag and discard");

  a_oversize_stall: assert property (@(posedge mclk_i) disable iff (!nrst_i) // [R7]
    ov_req |=> resp_sel_reg[{$past(link_ev_i.pipe), 1'b0} +: 2] == 2'h3)
    else $error("oversize packet did not force stall");

  a_stall_role: assert property (@(posedge mclk_i) disable iff (!nrst_i) // [R8]
    ov_req |=> link_o.stall_hs == !$past(host_reg))
    else $error("stall handshake wrong for role");

  a_clear_silent: assert property (@(posedge mclk_i) disable iff (!nrst_i) // [R5]
    (link_ev_i.sw_clear && !ov_req) |=> !link_o.empty_req)
    else $error("software clear raised empty request");

  a_err_blocks: assert property (@(posedge mclk_i) disable iff (!nrst_i) // [R9]
    (link_ev_i.rx_err || link_ev_i.setup_active) && !tx_req |=> !link_o.empty_req && !link_o.discard)
    else $error("oversize request raised on error or setup");

  a_status_zlp: assert property (@(posedge mclk_i) disable iff (!nrst_i) // [R6]
    (!host_reg && link_ev_i.status_zlp && !ov_req) |=> !link_o.empty_req)
    else $error("status stage packet raised empty request");

  a_ones_keep: assert property (@(posedge mclk_i) disable iff (!nrst_i) // [R10]
    (wr_en && hit(wr_addr, `UPES_IDX_EMPTY_FLAG) && &wr_data[`UPES_NUM_PIPES-1:0] && !emp_req)
    |=> $stable(pipe_empty_flag_reg))
    else $error("writing ones changed empty flags");

  a_ovr_not_ready: assert property (@(posedge mclk_i) disable iff (!nrst_i) // [R12]
    ovr_set |=> ovr_reg && link_o.not_ready)
    else $error("overrun without flag or not-ready request");

  a_crc_not_ready: assert property (@(posedge mclk_i) disable iff (!nrst_i) // [R17]
    crc_set |=> crc_reg && link_o.not_ready)
    else $error("crc error without flag or not-ready request");

  a_int_pin: assert property (@(posedge mclk_i) disable iff (!nrst_i) // [R1]
    |(pipe_empty_flag_reg & pipe_empty_irq_enable_reg) |=> !int_n_o || $past(wr_en))
    else $error("enabled empty flag did not assert interrupt");
endmodule // upes_top

// File: sim/upes_link_model.sv
// far-side link engine model: one-cycle transfer, iso and sof reports
// assumes the bench calls ev from the mclk_i domain
module upes_link_model (
  input wire logic mclk_i,
  output upes_pkg::upes_link_ev_s link_ev_o,
  output upes_pkg::upes_iso_ev_s iso_ev_o,
  output upes_pkg::upes_sof_rx_s sof_rx_o
);
  timeunit 1ns;
  timeprecision 1ps;
  import upes_pkg::*;
  // idle: no reports
  initial
  begin
    link_ev_o = '0;
    iso_ev_o = '0;
    sof_rx_o = '0;
  end
  // report for one cycle after an edge, then withdraw
  task automatic ev(input upes_link_ev_s l, input upes_iso_ev_s i, input upes_sof_rx_s s);
    @(posedge mclk_i);
    link_ev_o <= l;
    iso_ev_o <= i;
    sof_rx_o <= s;
    @(posedge mclk_i);
    link_ev_o <= '0;
    iso_ev_o <= '0;
    sof_rx_o <= {1'b0, ~s.frame, ~s.uframe}; // stale fields inverted
  endtask
endmodule // upes_link_model

// File: sim/usb_pipe_empty_and_frame_status_tb.sv
// bench for the pipe empty / frame status block: bus tasks and event scenarios
// assumes upes_defs.svh on the include path and upes_link_model compiled first
`include "upes_defs.svh"
module usb_pipe_empty_and_frame_status_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import upes_pkg::*;
  logic mclk_i = 0;
  logic nrst_i = 0;
  logic [11:0] aw_addr = '0, ar_addr = '0;
  logic aw_valid = 0, w_valid = 0, b_ready = 0, ar_valid = 0, r_ready = 0, hs0 = 0, hs1 = 0;
  logic [31:0] w_data = '0, rd, rd2, r_data;
  logic [3:0] w_strb = '0;
  logic aw_ready, w_ready, b_valid, ar_ready, r_valid, int_n;
  logic [1:0] b_resp, r_resp, rr, br;
  logic [19:0] prs;
  logic [10:0] f;
  logic [2:0] u;
  logic [10:0] sup [5] = '{11'h780, 11'h640, 11'h620, 11'h00E, 11'h00D};
  logic [4:0] isoc [3] = '{5'h10, 5'h04, 5'h01};
  upes_link_ev_s lev;
  upes_iso_ev_s iev;
  upes_sof_rx_s sev;
  upes_link_out_s lo;
  int mismatches = 0, cmp_count = 0, p, n;
  localparam int UCYC = 20;
  // clock
  initial forever #5 mclk_i = ~mclk_i;
  upes_top #(.UFRAME_CYC(UCYC)) i_upes_top (.mclk_i(mclk_i), .nrst_i(nrst_i), .s_axil_awaddr_i(aw_addr),
    .s_axil_awvalid_i(aw_valid), .s_axil_awready_o(aw_ready), .s_axil_wdata_i(w_data), .s_axil_wstrb_i(w_strb),
    .s_axil_wvalid_i(w_valid), .s_axil_wready_o(w_ready), .s_axil_bresp_o(b_resp), .s_axil_bvalid_o(b_valid),
    .s_axil_bready_i(b_ready), .s_axil_araddr_i(ar_addr), .s_axil_arvalid_i(ar_valid),
    .s_axil_arready_o(ar_ready), .s_axil_rdata_o(r_data), .s_axil_rresp_o(r_resp), .s_axil_rvalid_o(r_valid),
    .s_axil_rready_i(r_ready), .link_ev_i(lev), .iso_ev_i(iev), .sof_rx_i(sev), .port0_hs_i(hs0),
    .port1_hs_i(hs1), .link_o(lo), .pipe_response_select_o(prs), .int_n_o(int_n));
  upes_link_model i_upes_link_model (.mclk_i(mclk_i), .link_ev_o(lev), .iso_ev_o(iev), .sof_rx_o(sev));
  // expected frame register word
  function automatic logic [31:0] fw(input logic o, input logic c, input logic [10:0] fr);
    return {16'h0000, o, c, 3'h0, fr};
  endfunction
  // expected microframe word
  function automatic logic [31:0] uf(input logic [2:0] m, input logic h);
    return h ? {29'h0, m} : 32'h0000_0000;
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // bus write: address and data offered together, each released when taken
  task automatic wr(input logic [11:0] idx, input logic [31:0] d, input logic [3:0] s = 4'hF);
    @(posedge mclk_i);
    aw_addr <= idx << 2;
    aw_valid <= 1;
    w_data <= d;
    w_strb <= s;
    w_valid <= 1;
    b_ready <= 1;
    do
    begin
      @(posedge mclk_i);
      if (aw_valid && aw_ready) aw_valid <= 0;
      if (w_valid && w_ready) w_valid <= 0;
    end while (!(b_valid && b_ready));
    br = b_resp;
    b_ready <= 0;
  endtask
  task automatic rdr(input logic [11:0] idx);
    @(posedge mclk_i);
    ar_addr <= idx << 2;
    ar_valid <= 1;
    r_ready <= 1;
    do
    begin
      @(posedge mclk_i);
      if (ar_valid && ar_ready) ar_valid <= 0;
    end while (!(r_valid && r_ready));
    rd = r_data;
    rr = r_resp;
    r_ready <= 0;
  endtask
  // one report from the far side, then let the answer edge settle
  task automatic go(input upes_link_ev_s l, input upes_iso_ev_s i, input upes_sof_rx_s s);
    i_upes_link_model.ev(l, i, s);
    #1;
  endtask
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // watchdog
  initial
  begin
    #(20000 * 10);
    mismatches++;
    final_report();
  end
  // main sequence
  initial
  begin
    void'($urandom(74));
    repeat (20) @(posedge mclk_i);
    nrst_i <= 1;
    rdr(`UPES_IDX_FRAME);
    chk(rd, 0);
    rdr(`UPES_IDX_UFRAME);
    chk(rd, 0);
    rdr(12'h001);
    chk(rr, `UPES_RESP_SLVERR);
    wr(12'h001, 32'hFFFF_FFFF);
    chk(br, `UPES_RESP_SLVERR);
    $display("reset test done");
    wr(`UPES_IDX_RESP_SEL, 32'h0005_5555);
    for (int k = 0; k < 2; k++)
    begin
      p = k ? 1 + $urandom % 9 : 0;
      wr(`UPES_IDX_EMPTY_EN, 32'h1 << p);
      go({11'h600, 4'(p)}, '0, '0);
      chk({lo.empty_req, lo.rdy_ev, lo.pipe}, {1'b1, 1'(p != 0), 4'(p)});
      @(posedge mclk_i);
      #1;
      chk(int_n, 0);
      rdr(`UPES_IDX_EMPTY_FLAG);
      chk(rd, 32'h1 << p);
      rdr(`UPES_IDX_INT_MAIN);
      chk(rd[`UPES_INT_EMPTY_BIT], 1);
      wr(`UPES_IDX_EMPTY_FLAG, ~(32'h1 << p));
      rdr(`UPES_IDX_EMPTY_FLAG);
      chk(rd, 0);
      chk(int_n, 1);
    end
    $display("empty test done");
    foreach (sup[i])
    begin
      go({sup[i], 4'h3}, '0, '0);
      chk(lo.empty_req, 0);
    end
    rdr(`UPES_IDX_EMPTY_FLAG);
    chk(rd, 0);
    $display("suppress test done");
    for (int r = 0; r < 2; r++)
    begin
      wr(`UPES_IDX_CTRL, 32'(r));
      p = 1 + $urandom % 9;
      go({11'h00C, 4'(p)}, '0, '0);
      chk({lo.empty_req, lo.discard, lo.stall_hs}, {2'b11, 1'(r == 0)});
      @(posedge mclk_i);
      #1;
      chk(prs[2*p +: 2], `UPES_RSEL_STALL);
      rdr(`UPES_IDX_EMPTY_FLAG);
      chk(rd, 32'h1 << p);
      wr(`UPES_IDX_EMPTY_FLAG, 32'hFFFF_FFFF);
      rdr(`UPES_IDX_EMPTY_FLAG);
      chk(rd, 32'h1 << p);
      wr(`UPES_IDX_EMPTY_FLAG, 0);
    end
    wr(`UPES_IDX_CTRL, 0);
    $display("oversize test done");
    foreach (isoc[i])
    begin
      go('0, {isoc[i], 4'(i + 1)}, '0);
      chk({lo.not_ready, lo.not_ready_pipe}, {1'b1, 4'(i + 1)});
    end
    rdr(`UPES_IDX_FRAME);
    chk(rd, fw(1, 1, 0));
    wr(`UPES_IDX_FRAME, 32'h4000, 4'h3);
    rdr(`UPES_IDX_FRAME);
    chk(rd, fw(0, 1, 0));
    wr(`UPES_IDX_FRAME, 32'h8000, 4'h3);
    rdr(`UPES_IDX_FRAME);
    chk(rd, fw(0, 0, 0));
    $display("iso test done");
    repeat (4)
    begin
      f = 11'($urandom);
      u = 3'($urandom);
      {hs1, hs0} <= 2'($urandom);
      go('0, '0, {1'b1, f, u});
      rdr(`UPES_IDX_FRAME);
      rd2 = rd;
      rdr(`UPES_IDX_FRAME);
      chk(rd2, rd);
      chk(rd, fw(0, 0, f));
      rdr(`UPES_IDX_UFRAME);
      chk(rd, uf(u, hs0 | hs1));
    end
    $display("frame test done");
    // host role: issued start-of-frame spacing and frame increments
    wr(`UPES_IDX_CTRL, 32'h1);
    rdr(`UPES_IDX_FRAME);
    chk(rd, fw(0, 0, f));
    for (int s = 0; s < 2; s++)
    begin
      n = 0;
      do
      begin
        @(posedge mclk_i);
        n++;
      end while (!lo.sof_issue);
    end
    chk(n, `UPES_UFRAMES * UCYC);
    rdr(`UPES_IDX_FRAME);
    chk(rd, fw(0, 0, f + 11'h002));
    $display("host frame test done");
    final_report();
  end
endmodule // usb_pipe_empty_and_frame_status_tb
